// ===== include/pto_pkg.sv
// Purpose: Shared constants and types of the timer output and pulse control block.
// Assumes: AXI4-Lite with 32-bit data and 8-bit byte addresses.
// Notes: Each register takes one aligned word.
package pto_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OUT = 8'h04;
  localparam logic [7:0] OFF_PRESC = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_DUTY = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFF_CAP_A = 8'h20;
  localparam logic [7:0] OFF_CAP_B = 8'h24;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_PIN_OUT_BIT = 1;
  localparam int unsigned CTRL_CLEAR_BIT = 2;
  localparam int unsigned OUT_INV_PERIOD_BIT = 0;
  localparam int unsigned OUT_INV_DUTY_BIT = 1;
  localparam int unsigned OUT_TOE_BIT = 2;
  localparam int unsigned OUT_OSPE_BIT = 3;
  localparam int unsigned OUT_SET_LVL_BIT = 4;
  localparam int unsigned OUT_RST_LVL_BIT = 5;
  localparam int unsigned OUT_TRIG_BIT = 6;
  localparam int unsigned PRESC_CLK_LSB = 0;
  localparam int unsigned PRESC_EDGE_A_LSB = 2;
  localparam int unsigned PRESC_EDGE_B_LSB = 4;
  localparam int unsigned IRQ_PERIOD_BIT = 0;
  localparam int unsigned IRQ_DUTY_BIT = 1;
  localparam int unsigned IRQ_CAP_A_BIT = 2;
  localparam int unsigned IRQ_CAP_B_BIT = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [3:0] OUT_RESET = 4'h0;
  localparam logic [5:0] PRESC_RESET = 6'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [3:0] IRQ_MASK_RESET = 4'hF;
  localparam logic [1:0] CLK_DIV1 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV4 = 2'h2;
  localparam logic [1:0] CLK_EDGE_A = 2'h3;
  localparam logic [1:0] RING_DIV_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PTO_EDGE_NONE = 2'h0,
    PTO_EDGE_RISE = 2'h1,
    PTO_EDGE_FALL = 2'h2,
    PTO_EDGE_BOTH = 2'h3
  } pto_edge_type;
  typedef enum logic [1:0] {
    PTO_OS_IDLE = 2'h0,
    PTO_OS_ACTIVE = 2'h1
  } pto_os_state_type;
endpackage

// ===== design/pto_edge_det.sv
// Purpose: Valid-edge detector for one synchronised capture input.
// Assumes: The input is already synchronised to aclk.
// Notes: The previous level starts low so a high input is seen as rising at first enable.
`timescale 1ns/1ps
module pto_edge_det
  import pto_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic level,
  input wire logic run,
  input wire logic ever_run,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse
);
  logic prev_q;
  logic prev_d;
  logic rise;
  logic fall;

  always_comb begin
    rise = level & ~prev_q;
    fall = ~level & prev_q;
    prev_d = prev_q;
    if (run || ever_run) begin
      prev_d = level; // RULE_09
    end
    edge_pulse = 1'b0;
    if (run) begin
      case (edge_sel)
        PTO_EDGE_RISE: edge_pulse = rise; // RULE_08
        PTO_EDGE_FALL: edge_pulse = fall;
        PTO_EDGE_BOTH: edge_pulse = rise | fall; // RULE_08
        default: edge_pulse = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= prev_d;
    end
  end
endmodule

// ===== design/pto_timer_out.sv
// Purpose: 16-bit timer output control, one-shot trigger and pulse generation with AXI4-Lite.
// Assumes: Pins are asynchronous and pass two flip-flops; aresetn is synchronous.
// Notes: The status register clears on read; the interrupt is a level.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// What the block and its software must do
// RULE_01: Software sets the one-shot trigger only while one-shot mode is enabled.
// RULE_02: Software spaces trigger writes by at least two count clocks.
// RULE_03: Software never sets the set-level bit before or together with the output enable.
// RULE_04: Software writes inversions, enable and one-shot mode first, levels in a later write.
// RULE_05: When the CPU runs from the ring oscillator the count clock is that clock divided.
// RULE_06: Software writes the prescaler only while the counter is stopped.
// RULE_07: Software does not pair capture input A as count clock with it as trigger or clear.
// RULE_08: A capture input high after reset gives a rising edge at first enable.
// RULE_09: A capture input high at re-enable after a stop gives no rising edge.
// RULE_10: The shared pin is either capture input B or the timer output, never both.
// RULE_11: Software keeps the duty value strictly below the period value.
// RULE_12: The pulse period is period plus one count clocks and the width duty plus one.
// RULE_13: Software clears duty inversion and masks the duty interrupt before a duty rewrite.
// RULE_14: Software waits one count clock, restores duty inversion, then clears the flag.
// RULE_15: The one-shot trigger bit clears itself and always reads zero.
// RULE_16: The set-level and reset-level bits always read zero.
// RULE_17: With inversion enabled the output toggles on each period or duty match.
module pto_timer_out
  import pto_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_input_a,
  input wire logic shared_port_pin_i,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe,
  input wire logic cpu_on_internal_ring_oscillator,
  input wire logic internal_ring_oscillator,
  output logic irq
);
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [3:0] outctl_q, outctl_d;
  logic [5:0] presc_q, presc_d;
  logic [15:0] period_compare_reg_q, period_compare_reg_d;
  logic [15:0] duty_compare_reg_q, duty_compare_reg_d;
  logic [15:0] main_counter_q, main_counter_d;
  logic [15:0] cap_a_q, cap_a_d, cap_b_q, cap_b_d;
  logic [3:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  logic out_ff_q, out_ff_d, pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
  pto_os_state_type os_state_q, os_state_d;
  logic ever_run_q, ever_run_d;
  logic [1:0] div_q, div_d, ring_div_q, ring_div_d;
  logic cap_a_s1_q, cap_a_s2_q, shared_s1_q, shared_s2_q;
  logic ring_sel_s1_q, ring_sel_s2_q, ring_s1_q, ring_s2_q, ring_prev_q;
  logic edge_a, edge_b, running, tick, ring_edge, period_hit, duty_hit;
  logic aw_take, w_take, do_write, ar_take;
  logic [7:0] wr_addr;
  logic [31:0] wr_data, wr_merge, wr_mask;
  logic [3:0] wr_strb, irq_events;

  pto_edge_det u_edge_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(cap_a_s2_q),
    .run(ctrl_q[CTRL_RUN_BIT]),
    .ever_run(ever_run_q),
    .edge_sel(presc_q[PRESC_EDGE_A_LSB +: 2]),
    .edge_pulse(edge_a)
  );

  // Capture input B is only listened to while the shared pin is an input.
  pto_edge_det u_edge_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(shared_s2_q & ~ctrl_q[CTRL_PIN_OUT_BIT]), // RULE_10
    .run(ctrl_q[CTRL_RUN_BIT]),
    .ever_run(ever_run_q),
    .edge_sel(presc_q[PRESC_EDGE_B_LSB +: 2]),
    .edge_pulse(edge_b)
  );

  always_comb begin
    ring_edge = ring_s2_q & ~ring_prev_q;
    ring_div_d = ring_edge ? ring_div_q + 2'h1 : ring_div_q;
    div_d = div_q + 2'h1;
    if (ring_sel_s2_q) begin
      tick = ring_edge && (ring_div_q == RING_DIV_LAST); // RULE_05
    end else begin
      case (presc_q[PRESC_CLK_LSB +: 2])
        CLK_DIV1: tick = 1'b1;
        CLK_DIV2: tick = div_q[0];
        CLK_DIV4: tick = (div_q == 2'h3);
        CLK_EDGE_A: tick = edge_a;
        default: tick = 1'b0;
      endcase
    end
  end

  always_comb begin
    aw_take = s_axi_awvalid & awready_q;
    w_take = s_axi_wvalid & wready_q;
    ar_take = s_axi_arvalid & arready_q;
    awaddr_d = aw_take ? s_axi_awaddr : awaddr_q;
    wdata_d = w_take ? s_axi_wdata : wdata_q;
    wstrb_d = w_take ? s_axi_wstrb : wstrb_q;
    aw_held_d = aw_held_q | aw_take;
    w_held_d = w_held_q | w_take;
    do_write = aw_held_d & w_held_d & ~bvalid_q;
    wr_addr = awaddr_d;
    wr_data = wdata_d;
    wr_strb = wstrb_d;
    wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wr_merge = 32'h0000_0000;
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    outctl_d = outctl_q;
    presc_d = presc_q;
    period_compare_reg_d = period_compare_reg_q;
    duty_compare_reg_d = duty_compare_reg_q;
    irq_mask_d = irq_mask_q;
    out_ff_d = out_ff_q;
    os_state_d = os_state_q;
    main_counter_d = main_counter_q;
    cap_a_d = cap_a_q;
    cap_b_d = cap_b_q;
    irq_stat_d = irq_stat_q;
    running = ctrl_q[CTRL_RUN_BIT] &
      (~outctl_q[OUT_OSPE_BIT] | (os_state_q == PTO_OS_ACTIVE));
    period_hit = running & tick & (main_counter_q == period_compare_reg_q);
    duty_hit = running & tick & (main_counter_q == duty_compare_reg_q);
    ever_run_d = ever_run_q | ctrl_q[CTRL_RUN_BIT];
    if (!ctrl_q[CTRL_RUN_BIT]) begin
      main_counter_d = 16'h0000;
      os_state_d = PTO_OS_IDLE;
    end else if (running && tick) begin
      if (period_hit && (ctrl_q[CTRL_CLEAR_BIT] || outctl_q[OUT_OSPE_BIT])) begin
        main_counter_d = 16'h0000; // RULE_12
      end else begin
        main_counter_d = main_counter_q + 16'h0001;
      end
    end
    if (period_hit && outctl_q[OUT_OSPE_BIT]) begin
      os_state_d = PTO_OS_IDLE;
    end
    if ((period_hit && outctl_q[OUT_INV_PERIOD_BIT]) ^
        (duty_hit && outctl_q[OUT_INV_DUTY_BIT])) begin
      out_ff_d = ~out_ff_q; // RULE_17
    end
    if (edge_a) begin
      cap_a_d = main_counter_q;
    end
    if (edge_b) begin
      cap_b_d = main_counter_q;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (wr_addr)
        OFF_CTRL: begin
          wr_merge = (wr_data & wr_mask) | ({29'h0, ctrl_q} & ~wr_mask);
          ctrl_d = wr_merge[2:0];
        end
        OFF_OUT: begin
          wr_merge = (wr_data & wr_mask) | ({28'h0, outctl_q} & ~wr_mask);
          outctl_d = wr_merge[3:0];
          if (wr_strb[0] && wr_data[OUT_SET_LVL_BIT]) begin
            out_ff_d = 1'b1;
          end else if (wr_strb[0] && wr_data[OUT_RST_LVL_BIT]) begin
            out_ff_d = 1'b0;
          end
          // The trigger is an action only; nothing of it is stored.
          if (wr_strb[0] && wr_data[OUT_TRIG_BIT] && wr_merge[OUT_OSPE_BIT] &&
              ctrl_q[CTRL_RUN_BIT] && (os_state_q == PTO_OS_IDLE)) begin
            os_state_d = PTO_OS_ACTIVE; // RULE_15
            main_counter_d = 16'h0000;
          end
        end
        OFF_PRESC: begin
          wr_merge = (wr_data & wr_mask) | ({26'h0, presc_q} & ~wr_mask);
          presc_d = wr_merge[5:0];
        end
        OFF_PERIOD: begin
          wr_merge = (wr_data & wr_mask) | ({16'h0, period_compare_reg_q} & ~wr_mask);
          period_compare_reg_d = wr_merge[15:0];
        end
        OFF_DUTY: begin
          wr_merge = (wr_data & wr_mask) | ({16'h0, duty_compare_reg_q} & ~wr_mask);
          duty_compare_reg_d = wr_merge[15:0];
        end
        OFF_IRQ_MASK: begin
          wr_merge = (wr_data & wr_mask) | ({28'h0, irq_mask_q} & ~wr_mask);
          irq_mask_d = wr_merge[3:0];
        end
        OFF_COUNT, OFF_IRQ_STAT, OFF_CAP_A, OFF_CAP_B: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = ~aw_held_d & ~bvalid_d;
    wready_d = ~w_held_d & ~bvalid_d;
    rvalid_d = rvalid_q & ~s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: rdata_d = {29'h0, ctrl_q};
        OFF_OUT: rdata_d = {28'h0, outctl_q}; // RULE_16
        OFF_PRESC: rdata_d = {26'h0, presc_q};
        OFF_PERIOD: rdata_d = {16'h0, period_compare_reg_q};
        OFF_DUTY: rdata_d = {16'h0, duty_compare_reg_q};
        OFF_COUNT: rdata_d = {16'h0, main_counter_q};
        OFF_IRQ_STAT: begin
          rdata_d = {28'h0, irq_stat_q};
          irq_stat_d = 4'h0;
        end
        OFF_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
        OFF_CAP_A: rdata_d = {16'h0, cap_a_q};
        OFF_CAP_B: rdata_d = {16'h0, cap_b_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    arready_d = ~rvalid_d;
    // New events are merged after the read clear so none is lost.
    irq_events = {edge_b, edge_a, duty_hit, period_hit};
    irq_stat_d = irq_stat_d | irq_events;
    irq_d = |(irq_stat_d & ~irq_mask_d);
    pin_oe_d = ctrl_d[CTRL_PIN_OUT_BIT]; // RULE_10
    pin_o_d = ctrl_d[CTRL_PIN_OUT_BIT] & outctl_d[OUT_TOE_BIT] & out_ff_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RESET;
      outctl_q <= OUT_RESET;
      presc_q <= PRESC_RESET;
      period_compare_reg_q <= CMP_RESET;
      duty_compare_reg_q <= CMP_RESET;
      main_counter_q <= CMP_RESET;
      cap_a_q <= CMP_RESET;
      cap_b_q <= CMP_RESET;
      irq_stat_q <= 4'h0;
      irq_mask_q <= IRQ_MASK_RESET;
      irq_q <= 1'b0;
      out_ff_q <= 1'b0;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      os_state_q <= PTO_OS_IDLE;
      ever_run_q <= 1'b0;
      div_q <= 2'h0;
      ring_div_q <= 2'h0;
      cap_a_s1_q <= 1'b0;
      cap_a_s2_q <= 1'b0;
      shared_s1_q <= 1'b0;
      shared_s2_q <= 1'b0;
      ring_sel_s1_q <= 1'b0;
      ring_sel_s2_q <= 1'b0;
      ring_s1_q <= 1'b0;
      ring_s2_q <= 1'b0;
      ring_prev_q <= 1'b0;
    end else if (ce) begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      outctl_q <= outctl_d;
      presc_q <= presc_d;
      period_compare_reg_q <= period_compare_reg_d;
      duty_compare_reg_q <= duty_compare_reg_d;
      main_counter_q <= main_counter_d;
      cap_a_q <= cap_a_d;
      cap_b_q <= cap_b_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      out_ff_q <= out_ff_d;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      os_state_q <= os_state_d;
      ever_run_q <= ever_run_d;
      div_q <= div_d;
      ring_div_q <= ring_div_d;
      cap_a_s1_q <= capture_input_a;
      cap_a_s2_q <= cap_a_s1_q;
      shared_s1_q <= shared_port_pin_i;
      shared_s2_q <= shared_s1_q;
      ring_sel_s1_q <= cpu_on_internal_ring_oscillator;
      ring_sel_s2_q <= ring_sel_s1_q;
      ring_s1_q <= internal_ring_oscillator;
      ring_s2_q <= ring_s1_q;
      ring_prev_q <= ring_s2_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign shared_port_pin_o = pin_o_q;
  assign shared_port_pin_oe = pin_oe_q;
  assign irq = irq_q;
endmodule

// ===== tb/pto_timer_out_monitor.sv
// Purpose: Port checker for the timer output block.
// Assumes: Single clock domain with synchronous active-low reset.
// Notes: Attached to every instance of the top module by bind.
`timescale 1ns/1ps
module pto_timer_out_monitor
  import pto_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shared_port_pin_o,
  input wire logic shared_port_pin_oe,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_answer;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  read_answer_a: assert property (ar_take |=> rd_answer)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  write_answer_a: assert property (wr_take |=> s_axi_bvalid && !s_axi_awready)
    else $error("write answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  bad_read_a: assert property (ar_take and s_axi_araddr > 8'h24 |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  level_bits_a: assert property (ar_take and s_axi_araddr == OFF_OUT |=>
    s_axi_rdata[6:4] == 3'h0) else $error("self clearing bits read nonzero");
  pin_share_a: assert property (!shared_port_pin_oe |-> !shared_port_pin_o)
    else $error("pin output active while released");
  irq_masked_a: assert property (wr_take and s_axi_awaddr == OFF_IRQ_MASK && s_axi_wstrb[0] &&
    s_axi_wdata[3:0] == 4'hF |-> ##[2:3] !irq) else $error("masked interrupt raised");
endmodule
bind pto_timer_out pto_timer_out_monitor mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shared_port_pin_o, .shared_port_pin_oe, .irq);

// ===== tb/pto_pin_model.sv
// Purpose: Outside world of the capture pins, the shared pin and the slow oscillator.
// Assumes: Commanded levels change the pins one clock later.
// Notes: The slow oscillator runs free at one eighth of aclk.
`timescale 1ns/1ps
module pto_pin_model (
  input wire logic aclk,
  input wire logic lvl_a,
  input wire logic lvl_b,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic cap_a,
  output logic pin_i,
  output logic ring
);
  logic [2:0] div_q = 3'h0;
  logic b_q = 1'b0;
  always @(posedge aclk) begin
    cap_a <= lvl_a;
    b_q <= lvl_b;
    div_q <= div_q + 3'h1;
  end
  assign ring = div_q[2];
  // The pin shows the block's level while it drives, else the outside level.
  assign pin_i = pin_oe ? pin_o : b_q;
endmodule

// ===== tb/ppg_timer_output_control_bench.sv
// Purpose: Self-checking bench of the timer output block.
// Assumes: Expected values come from the register layout and the pulse rules.
// Notes: Read and write results are compared by a watcher against queued notes.
`timescale 1ns/1ps
module ppg_timer_output_control_bench
  import pto_pkg::*;
();
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, lvl_a = 1'b1, lvl_b = 1'b0, ring_sel = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic capture_input_a, shared_port_pin_i, shared_port_pin_o, shared_port_pin_oe, irq, ring;
  int errors = 0, checks_done = 0, seed = 68, n, hi, lo;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] p, d;
  pto_timer_out uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .capture_input_a, .shared_port_pin_i, .shared_port_pin_o,
    .shared_port_pin_oe, .cpu_on_internal_ring_oscillator(ring_sel), .internal_ring_oscillator(ring), .irq);
  pto_pin_model pins (.aclk, .lvl_a, .lvl_b, .pin_o(shared_port_pin_o),
    .pin_oe(shared_port_pin_oe), .cap_a(capture_input_a), .pin_i(shared_port_pin_i), .ring);
  initial forever #2.5 aclk = ~aclk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("BAD wait exp done seen timeout");
    stop_test();
  endtask
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r = RESP_OKAY);
    int k;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 100) hang();
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    int k;
    rq.push_back({r, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 100) hang();
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wl(input logic v, output int c);
    c = 0;
    while (shared_port_pin_o !== v) begin
      @(posedge aclk);
      c++;
      if (c > 2000) hang();
    end
  endtask
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) check("bresp", 34'(s_axi_bresp), 34'(bq.pop_front()));
    if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_OUT, 32'h0);
    rd(OFF_IRQ_MASK, 32'hF);
    rd(8'h3C, 32'h0, RESP_SLVERR);
    wr(8'h3C, 32'h1, RESP_SLVERR);
    $display("test reset done");
    wr(OFF_PERIOD, 32'hFFFF);
    wr(OFF_DUTY, 32'hFFFE);
    wr(OFF_PRESC, 32'h4);
    wr(OFF_CTRL, 32'h1);
    repeat (10) @(posedge aclk);
    check("irq", 34'(irq), 34'h0);
    wr(OFF_IRQ_MASK, 32'hB);
    repeat (3) @(posedge aclk);
    check("irq", 34'(irq), 34'h1);
    rd(OFF_IRQ_STAT, 32'h4);
    repeat (3) @(posedge aclk);
    check("irq", 34'(irq), 34'h0);
    wr(OFF_CTRL, 32'h0);
    repeat (5) @(posedge aclk);
    wr(OFF_CTRL, 32'h1);
    repeat (10) @(posedge aclk);
    rd(OFF_IRQ_STAT, 32'h0);
    $display("test capture done");
    wr(OFF_CTRL, 32'h0);
    wr(OFF_IRQ_MASK, 32'hF);
    wr(OFF_PRESC, 32'h30);
    repeat (3) begin
      p = 16'h4 + 16'($unsigned($random(seed)) % 12);
      d = 16'($unsigned($random(seed)) % p);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_PERIOD, {16'h0, p});
      wr(OFF_DUTY, {16'h0, d});
      wr(OFF_OUT, 32'h7);
      wr(OFF_OUT, 32'h17);
      rd(OFF_OUT, 32'h7);
      wr(OFF_CTRL, 32'h7);
      wl(1'b1, n);
      wl(1'b0, n);
      wl(1'b1, n);
      wl(1'b0, hi);
      wl(1'b1, lo);
      check("high", 34'(hi), 34'(d) + 34'h1);
      check("period", 34'(hi + lo), 34'(p) + 34'h1);
      rd(OFF_IRQ_STAT, 32'h3);
    end
    wr(OFF_OUT, 32'h5);
    wr(OFF_IRQ_MASK, 32'hF);
    d = p - 16'h1;
    wr(OFF_DUTY, {16'h0, d});
    @(posedge aclk);
    wr(OFF_OUT, 32'h7);
    repeat (16) @(posedge aclk);
    rd(OFF_IRQ_STAT, 32'h3);
    wl(1'b1, n);
    wl(1'b0, n);
    wl(1'b1, n);
    wl(1'b0, hi);
    wl(1'b1, lo);
    check("period", 34'(hi + lo), 34'(p) + 34'h1);
    ce <= 1'b0;
    @(posedge aclk);
    n = int'(shared_port_pin_o);
    repeat (40) @(posedge aclk);
    check("freeze", 34'(shared_port_pin_o), 34'(n));
    ce <= 1'b1;
    // The model's slow clock rises every 8 cycles and every fourth rise is one count tick.
    ring_sel <= 1'b1;
    wl(1'b1, n);
    wl(1'b0, n);
    wl(1'b1, n);
    wl(1'b0, hi);
    wl(1'b1, lo);
    check("ring", 34'(hi + lo), 34'((p + 1) * 8 * (RING_DIV_LAST + 1)));
    ring_sel <= 1'b0;
    repeat (4) @(posedge aclk);
    $display("test pulse done");
    wr(OFF_CTRL, 32'h0);
    wr(OFF_OUT, 32'h0D);
    wr(OFF_OUT, 32'h2D);
    wr(OFF_CTRL, 32'h3);
    wr(OFF_OUT, 32'h4D);
    wl(1'b1, n);
    check("oneshot", 34'(n), 34'(p));
    repeat (40) @(posedge aclk);
    check("oneshot", 34'(shared_port_pin_o), 34'h1);
    rd(OFF_OUT, 32'h0D);
    $display("test trigger done");
    stop_test();
  end
endmodule
